/* src/uft_fifo.sv */
`timescale 1ns/1ps
module uft_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } uft_fifo_st_t;

    uft_fifo_st_t st;
    uft_fifo_st_t next_st;
    logic push;
    logic pop;

    // Handshakes on both sides; full and empty come from the count.
    assign in_ready_o = (st.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st.count != '0);
    assign out_data_o = st.mem[st.rptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and storage update.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = in_data_i;
            next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : uft_fifo

/* src/uft_pkg.sv */
package uft_pkg;

    // ----------------------------------------------------------------
    // Frame format and prescaler encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;

    localparam logic [1:0] LEN_5 = 2'h0;
    localparam logic [1:0] LEN_8 = 2'h3;
    localparam int unsigned LEN_BASE = 5;

    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_DIV1 = 2'h3;

    localparam logic [5:0] PRE_CNT_1 = 6'h00;
    localparam logic [5:0] PRE_CNT_4 = 6'h03;
    localparam logic [5:0] PRE_CNT_12 = 6'h0B;
    localparam logic [5:0] PRE_CNT_48 = 6'h2F;

    // ----------------------------------------------------------------
    // Reset values and line levels
    // ----------------------------------------------------------------
    localparam logic [15:0] RELOAD_RST = 16'hFFE6;
    localparam logic TX_IDLE_LEVEL = 1'h1;
    localparam logic START_LEVEL = 1'h0;

    // ----------------------------------------------------------------
    // Frame configuration carried as one group
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] data_len;
        logic parity_enable;
        logic [1:0] parity_type_select;
        logic extra_bit_enable;
        logic tx_extra_bit_value;
        logic stop_long;
    } uft_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_DATA = 3'b010,
        ST_XTRA = 3'b011,
        ST_STOP = 3'b100
    } uft_state_t;

endpackage : uft_pkg

/* src/uft_tx.sv */
`timescale 1ns/1ps
// Summary of operation
// - Frame: start low, data LSB first, extra, stop
// - Data length five to eight bits
// - Hardware parity: even, odd, mark, space
// - Stop length short one, long longer
// - Two stops only above five data bits
// - Parity takes the extra bit position
// - Separate out and in pins, full duplex
// - Data write loads holding, clears empty
// - Idle shifter takes held data at once
// - Busy shifter leaves data held until stop ends
// - Done flag set at stop start
// - Extra bit value sent after data
// - Parity computed from data by type
// - Prescale 11, reload FFE6 gives 52
// - Timer counts up, reloads on overflow
// - Rate core over span, two, prescale
// - Parity type 00 odd 01 even 10 mark 11 space
module uft_tx
    import uft_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic baud_enable_i,
    input wire logic [1:0] baud_prescale_select_i,
    input wire logic [15:0] baud_reload_i,
    input wire uft_cfg_t cfg_i,
    input wire logic multiproc_enable_i,
    input wire logic serial_data_port_wr_i,
    input wire logic [7:0] serial_data_port_i,
    input wire logic tx_done_clr_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic tx_holding_empty_flag_o,
    output logic tx_done_flag_o,
    output logic tx_busy_o,
    output logic serial_in_sync_o,
    output logic multiproc_enable_o
);

    // ----------------------------------------------------------------
    // Types and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [5:0] pre_cnt;
        logic [15:0] timer;
        logic half_tick;
        logic [2:0] state;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic [1:0] half_cnt;
        logic par_acc;
        logic xtra_val;
        logic xtra_on;
        logic stop_long;
        logic txd;
        logic thre;
        logic done;
        logic [1:0] rx_sync;
        logic mce;
        logic busy;
    } uft_tx_st_t;

    uft_tx_st_t st;
    uft_tx_st_t next_st;
    uft_state_t cur;
    logic ovf;
    logic bit_tick;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_in_ready;
    logic [7:0] fifo_data;
    logic load;

    // Terminal count of the prescaler for a select code.
    function automatic logic [5:0] pre_limit(input logic [1:0] sel);
        unique case (sel)
            PRE_DIV12: pre_limit = PRE_CNT_12;
            PRE_DIV4: pre_limit = PRE_CNT_4;
            PRE_DIV48: pre_limit = PRE_CNT_48;
            PRE_DIV1: pre_limit = PRE_CNT_1;
        endcase
    endfunction : pre_limit

    // Parity bit for the selected type over the valid data bits.
    function automatic logic par_bit(input logic [1:0] ty, input logic ones);
        unique case (ty)
            PAR_ODD: par_bit = ~ones;
            PAR_EVEN: par_bit = ones;
            PAR_MARK: par_bit = 1'h1;
            PAR_SPACE: par_bit = 1'h0;
        endcase
    endfunction : par_bit

    assign cur = uft_state_t'(st.state);

    // ----------------------------------------------------------------
    // Holding buffer between the data port and the shifter
    // ----------------------------------------------------------------
    // The write port holds one byte; the buffer decouples it from the shifter.
    uft_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_hold (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(serial_data_port_wr_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i(serial_data_port_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready),
        .out_data_o(fifo_data)
    );

    // The shifter only pulls a byte when no frame is in progress.
    assign load = fifo_valid && (cur == ST_IDLE);
    assign fifo_ready = load;

    // Timer overflow in this cycle; acting on it at once keeps every half bit exact.
    assign ovf = baud_enable_i && (st.pre_cnt >= pre_limit(baud_prescale_select_i))
                 && (st.timer == 16'hFFFF);

    // Two timer overflows make one bit period; a single overflow is a half bit.
    assign bit_tick = ovf && st.half_cnt[0];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.half_tick = 1'b0;
        next_st.rx_sync = {st.rx_sync[0], serial_in_pin_i};
        next_st.mce = multiproc_enable_i;

        // Prescaled reload timer; it free-runs while enabled.
        if (baud_enable_i) begin
            if (st.pre_cnt >= pre_limit(baud_prescale_select_i)) begin
                next_st.pre_cnt = '0;
                if (st.timer == 16'hFFFF) begin
                    next_st.timer = baud_reload_i;
                    next_st.half_tick = 1'b1;
                end else begin
                    next_st.timer = st.timer + 16'h0001;
                end
            end else begin
                next_st.pre_cnt = st.pre_cnt + 6'h01;
            end
        end

        // Half-period counter paces every bit of the frame.
        if (ovf && cur != ST_IDLE) begin
            next_st.half_cnt = st.half_cnt + 2'h1;
        end

        // Holding flag: a write clears it, a load into the shifter sets it.
        if (serial_data_port_wr_i) begin
            next_st.thre = 1'b0;
        end
        if (!fifo_in_ready && !load) begin
            next_st.thre = 1'b0;
        end else if (load && !serial_data_port_wr_i) begin
            next_st.thre = 1'b1;
        end

        if (tx_done_clr_i) begin
            next_st.done = 1'b0;
        end

        unique case (cur)
            ST_IDLE: begin
                next_st.txd = TX_IDLE_LEVEL;
                if (load) begin
                    next_st.shift = fifo_data;
                    next_st.bit_cnt = {2'h0, cfg_i.data_len} + 4'(LEN_BASE);
                    next_st.par_acc = 1'b0;
                    next_st.xtra_on = cfg_i.parity_enable || cfg_i.extra_bit_enable;
                    next_st.xtra_val = cfg_i.tx_extra_bit_value;
                    next_st.stop_long = cfg_i.stop_long;
                    next_st.half_cnt = '0;
                    // Restart the rate timer so the start bit lasts a full period.
                    next_st.pre_cnt = '0;
                    next_st.timer = baud_reload_i;
                    next_st.txd = START_LEVEL;
                    next_st.state = ST_START;
                end
            end
            ST_START: begin
                if (bit_tick) begin
                    next_st.half_cnt = '0;
                    next_st.txd = st.shift[0];
                    next_st.par_acc = st.shift[0];
                    next_st.shift = {1'b0, st.shift[7:1]};
                    next_st.bit_cnt = st.bit_cnt - 4'h1;
                    next_st.state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (bit_tick) begin
                    next_st.half_cnt = '0;
                    if (st.bit_cnt != 4'h0) begin
                        next_st.txd = st.shift[0];
                        next_st.par_acc = st.par_acc ^ st.shift[0];
                        next_st.shift = {1'b0, st.shift[7:1]};
                        next_st.bit_cnt = st.bit_cnt - 4'h1;
                    end else if (st.xtra_on) begin
                        if (cfg_i.parity_enable) begin
                            next_st.txd = par_bit(cfg_i.parity_type_select, st.par_acc);
                        end else begin
                            next_st.txd = st.xtra_val;
                        end
                        next_st.state = ST_XTRA;
                    end else begin
                        next_st.txd = TX_IDLE_LEVEL;
                        next_st.done = 1'b1;
                        next_st.state = ST_STOP;
                    end
                end
            end
            ST_XTRA: begin
                if (bit_tick) begin
                    next_st.half_cnt = '0;
                    next_st.txd = TX_IDLE_LEVEL;
                    next_st.done = 1'b1;
                    next_st.state = ST_STOP;
                end
            end
            ST_STOP: begin
                // Short stop ends after two halves, long after three or four.
                if (ovf) begin
                    if (!st.stop_long && st.half_cnt == 2'h1) begin
                        next_st.state = ST_IDLE;
                    end else if (st.stop_long && st.half_cnt == 2'h2
                                 && cfg_i.data_len == LEN_5) begin
                        next_st.state = ST_IDLE;
                    end else if (st.stop_long && st.half_cnt == 2'h3) begin
                        next_st.state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        // Busy is registered so the output comes from a flip-flop.
        next_st.busy = (next_st.state != ST_IDLE);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.timer <= RELOAD_RST;
            st.txd <= TX_IDLE_LEVEL;
            st.thre <= 1'b1;
            st.state <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign serial_out_pin_o = st.txd;
    assign tx_holding_empty_flag_o = st.thre;
    assign tx_done_flag_o = st.done;
    assign tx_busy_o = st.busy;
    assign serial_in_sync_o = st.rx_sync[1];
    assign multiproc_enable_o = st.mce;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    idle_high_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cur == ST_IDLE && $past(cur) == ST_IDLE) |-> serial_out_pin_o)
        else $error("Output not high while idle.");

    start_low_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cur == ST_START |-> !serial_out_pin_o)
        else $error("Start bit not low.");

    stop_high_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cur == ST_STOP |-> serial_out_pin_o)
        else $error("Stop bit not high.");

    done_at_stop_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ($past(cur) != ST_STOP && cur == ST_STOP) |-> tx_done_flag_o)
        else $error("Done flag missing at stop start.");

    load_sets_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (load && !serial_data_port_wr_i && fifo_in_ready) |=> tx_holding_empty_flag_o)
        else $error("Holding flag not set after load.");

    write_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (serial_data_port_wr_i && !load) |=> !tx_holding_empty_flag_o)
        else $error("Holding flag not cleared on write.");

    busy_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cur != ST_IDLE) |-> !fifo_ready)
        else $error("Byte pulled during a frame.");

    timer_reload_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (baud_enable_i && st.timer == 16'hFFFF && st.pre_cnt >= pre_limit(baud_prescale_select_i))
        |=> (st.timer == $past(baud_reload_i) && st.half_tick))
        else $error("Timer did not reload on overflow.");

endmodule : uft_tx

/* verification/uft_rx_model.sv */
`timescale 1ns/1ps
module uft_rx_model (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic [7:0] bit_i,
    input wire logic [3:0] nbits_i,
    input wire logic xpos_i,
    output logic [7:0] data_o,
    output logic xbit_o,
    output logic framing_o,
    output int frames_o,
    output logic line_o
);
    // Far side transmit line rests high; the bench pulls it low on purpose.
    logic drive_low = 1'b0;
    assign line_o = ~drive_low;

    // Receiver samples the middle of each bit on the falling clock edge.
    initial begin
        frames_o = 0;
        forever begin
            @(negedge line_i);
            repeat (bit_i / 2) @(negedge clk_i);
            framing_o = ~line_i;
            data_o = 8'h00;
            for (int i = 0; i < nbits_i; i++) begin
                repeat (bit_i) @(negedge clk_i);
                data_o[i] = line_i;
            end
            if (xpos_i) begin
                repeat (bit_i) @(negedge clk_i);
                xbit_o = line_i;
            end
            repeat (bit_i) @(negedge clk_i);
            framing_o = framing_o & line_i;
            frames_o++;
        end
    end
endmodule : uft_rx_model

/* verification/uft_tx_tb.sv */
`timescale 1ns/1ps
module uft_tx_tb;
    import uft_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [1:0] pre = PRE_DIV1;
    logic [15:0] rel = 16'hFFFE;
    uft_cfg_t cfg = '0;
    logic mpe = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wd = 8'h00;
    logic clr = 1'b0;
    logic out, thre, done, busy, sync, mpe_o, rx_x, rx_f, pin;
    logic [7:0] rx_d;
    logic [7:0] bitp = 8'h04;
    int frames;
    int failures = 0;
    int check_count = 0;

    uft_tx i_uft_tx (.clk_i(clk_i), .srst_i(srst_i), .baud_enable_i(1'b1),
        .baud_prescale_select_i(pre), .baud_reload_i(rel), .cfg_i(cfg),
        .multiproc_enable_i(mpe), .serial_data_port_wr_i(wr),
        .serial_data_port_i(wd), .tx_done_clr_i(clr), .serial_in_pin_i(pin),
        .serial_out_pin_o(out), .tx_holding_empty_flag_o(thre),
        .tx_done_flag_o(done), .tx_busy_o(busy), .serial_in_sync_o(sync),
        .multiproc_enable_o(mpe_o));

    uft_rx_model i_uft_rx_model (.clk_i(clk_i), .line_i(out), .bit_i(bitp),
        .nbits_i(4'(cfg.data_len) + 4'h5),
        .xpos_i(cfg.parity_enable | cfg.extra_bit_enable), .data_o(rx_d),
        .xbit_o(rx_x), .framing_o(rx_f), .frames_o(frames), .line_o(pin));

    // Free running clock.
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // Expected bit in the position after the data field.
    function automatic logic expx(input uft_cfg_t c, input logic [7:0] d);
        if (!c.parity_enable) return c.tx_extra_bit_value;
        case (c.parity_type_select)
            PAR_ODD: return ~^d;
            PAR_EVEN: return ^d;
            PAR_MARK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : expx

    // One-cycle write pulse to the data port.
    task automatic wr_byte(input logic [7:0] b);
        @(negedge clk_i);
        wr = 1'b1;
        wd = b;
        @(negedge clk_i);
        wr = 1'b0;
    endtask : wr_byte

    // Sends one frame and judges its layout, timing and flags.
    task automatic frame(input uft_cfg_t c, input logic [7:0] b);
        int n, x, stp, len, td;
        n = int'(c.data_len) + 5;
        x = int'(c.parity_enable | c.extra_bit_enable);
        stp = !c.stop_long ? bitp : (n == 5 ? bitp * 3 / 2 : 2 * bitp);
        @(negedge clk_i);
        cfg = c;
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        check("done cleared", done, 1'b0);
        wr_byte(b);
        len = 0;
        td = -1;
        while (busy !== 1'b1 && len < 50) begin
            @(negedge clk_i);
            len++;
        end
        len = 0;
        while (busy === 1'b1 && len < 3000) begin
            if (done === 1'b1 && td < 0) td = len;
            @(negedge clk_i);
            len++;
        end
        check("frame length", len, (1 + n + x) * bitp + stp);
        check("done moment", td, (1 + n + x) * bitp);
        check("data", rx_d, b & (8'hFF >> (8 - n)));
        check("framing", rx_f, 1'b1);
        check("idle level", out, 1'b1);
        if (x != 0) check("extra", rx_x, expx(c, b & (8'hFF >> (8 - n))));
    endtask : frame

    // Every length with every parity type, extra bit and stop length.
    task automatic t_formats();
        for (int l = 0; l < 4; l++) begin
            for (int k = 0; k < 6; k++) begin
                frame('{2'(l), k < 4, 2'(k), k >= 4, k == 4, k[0]}, 8'(8'hA5 + l * 37 + k));
            end
        end
    endtask : t_formats

    // Bit period follows reload span and prescaler.
    task automatic t_rate();
        logic [1:0] codes [4] = '{PRE_DIV1, PRE_DIV4, PRE_DIV12, PRE_DIV48};
        int divs [4] = '{1, 4, 12, 48};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            pre = codes[i];
            rel = 16'hFFFF;
            bitp = 8'(2 * divs[i]);
            frame('{LEN_8, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0}, 8'h3C);
        end
        @(negedge clk_i);
        pre = PRE_DIV1;
        rel = RELOAD_RST;
        bitp = 8'd52;
        frame('{LEN_8, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0}, 8'hC3);
        @(negedge clk_i);
        rel = 16'hFFFE;
        bitp = 8'h04;
    endtask : t_rate

    // Back-to-back writes fill the buffer; the overflow byte is lost.
    task automatic t_burst();
        int f0, g;
        f0 = frames;
        @(negedge clk_i);
        i_uft_rx_model.drive_low = 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr = 1'b1;
            wd = 8'(8'h10 + i);
            @(negedge clk_i);
        end
        wr = 1'b0;
        check("holding flag", thre, 1'b0);
        check("input sync", sync, 1'b0);
        g = 0;
        while ((frames < f0 + 5 || busy !== 1'b0) && g < 2000) begin
            @(negedge clk_i);
            g++;
        end
        repeat (60) @(negedge clk_i);
        check("frames sent", frames - f0, 5);
        check("last byte", rx_d, 8'h14);
        check("holding empty", thre, 1'b1);
        i_uft_rx_model.drive_low = 1'b0;
        repeat (3) @(negedge clk_i);
        check("input sync idle", sync, 1'b1);
    endtask : t_burst

    // Stall watchdog.
    initial begin
        #500us;
        failures++;
        final_report();
    end

    // Reset, then the scenarios in turn.
    initial begin
        repeat (4) @(negedge clk_i);
        srst_i = 1'b0;
        @(negedge clk_i);
        check("out after reset", out, 1'b1);
        check("empty after reset", thre, 1'b1);
        check("done after reset", done, 1'b0);
        check("busy after reset", busy, 1'b0);
        mpe = 1'b1;
        repeat (2) @(negedge clk_i);
        check("multiproc", mpe_o, 1'b1);
        t_formats();
        t_rate();
        t_burst();
        final_report();
    end
endmodule : uft_tx_tb
